//--- verilog/osc_select_control.sv
// Oscillator select control: protected control register, tuning
// register, configuration word view and postscaler tick divider.
// Assumes an APB master on sys_clk_in and asynchronous oscillator
// status inputs (lock, failure, switch done) and config fuse pins.
//
// Notes on behaviour
// - Low control byte writable only after byte writes 0x46 then 0x57.
// - High control byte writable only after byte writes 0x78 then 0x9A.
// - After an unlock pair one following access may write; then relock.
// - Current group bits 14-12 are read-only, showing the active source.
// - Current group loads power-on group at reset, new group on switch done.
// - Detected clock failure forces current group to fast RC code.
// - New group bits 10-8 writable, reset to power-on group.
// - Postscaler bits 7-6 divide by 64, 16, 4 or 1.
// - Lock flag bit 5 reads PLL lock state.
// - Clock fail flag bit 3 set on failure, software clears it.
// - Bit 1 enables the 32 kHz secondary oscillator.
// - Bit 0 requests a switch; hardware clears it when done.
// - Unimplemented bits read zero.
// - Four-bit tuning field read/write, reset zero, signed steps.
// - Switch/monitor config: 1x none, 01 switching only, 00 both.
// - Power-on group field picks group used after reset.
// - Primary option field selects configuration within primary group.
// - On failure: load fast RC code, set fail flag, clear request.
// - Clearing the request mid-switch aborts the transition.
// - Switching disabled: current group follows power-on group directly.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module osc_select_control #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Oscillator status, asynchronous
  input wire logic pll_lock_in,
  input wire logic clock_fail_in,
  input wire logic switch_done_in,
  input wire logic [23:0] config_word_in,
  // Clock selection controls
  output logic [2:0] current_group_out,
  output logic [2:0] target_group_out,
  output logic switch_request_out,
  output logic [4:0] primary_option_out,
  output logic secondary_osc_enable_out,
  output logic [3:0] tune_field_out,
  output logic fail_safe_monitor_out,
  output logic postscaler_tick_out
);

  // ==========================================================
  // Parameter check
  if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr_w
    $error("osc_select_control: ADDR_W out of range");
  end

  // ==========================================================
  // Input synchronisers
  logic [12:0] sync1_q;
  logic [12:0] sync2_q;
  logic fail_prev_q;
  logic done_prev_q;
  wire logic [12:0] async_bus;

  // Raw inputs grouped for the two-stage chain
  assign async_bus = {pll_lock_in, clock_fail_in, switch_done_in,
                      config_word_in[15:14], config_word_in[10:8], config_word_in[4:0]};

  // Two flip-flops, not reset, first stage read only by the second
  always_ff @(posedge sys_clk_in) begin
    sync1_q <= async_bus;
    sync2_q <= sync1_q;
  end

  // Edge history from the second stage, kept through reset: no false event
  always_ff @(posedge sys_clk_in) begin
    fail_prev_q <= sync2_q[11];
    done_prev_q <= sync2_q[10];
  end

  wire logic lock_s;
  wire logic fail_evt_raw;
  wire logic done_evt;
  wire osc_pkg::osc_cfg_t cfg;
  wire logic sw_en;
  wire logic mon_en;
  wire logic fail_evt;

  // Decoded synchronised status
  assign lock_s = sync2_q[12];
  assign fail_evt_raw = sync2_q[11] & ~fail_prev_q;
  assign done_evt = sync2_q[10] & ~done_prev_q;
  assign cfg = sync2_q[9:0];
  assign sw_en = ~cfg.cksm[1];
  assign mon_en = (cfg.cksm == 2'h0);
  assign fail_evt = fail_evt_raw & mon_en;

  // ==========================================================
  // APB handshake: one wait state, data from flops
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  wire logic access;
  wire logic xfer;
  wire logic hit_ctrl;
  wire logic hit_tune;
  wire logic hit_cfgw;
  wire logic addr_hit;

  // Address decode
  assign hit_ctrl = (paddr_in[11:0] == osc_pkg::CTRL_OFS);
  assign hit_tune = (paddr_in[11:0] == osc_pkg::TUNE_OFS);
  assign hit_cfgw = (paddr_in[11:0] == osc_pkg::CFGW_OFS);
  assign addr_hit = hit_ctrl | hit_tune | hit_cfgw;
  assign access = psel_in & penable_in & ~pready_q;
  assign xfer = psel_in & penable_in & pready_q;

  // ==========================================================
  // Unlock state machines, one per byte
  osc_pkg::osc_unlock_t lo_st_q;
  osc_pkg::osc_unlock_t hi_st_q;
  wire logic ctrl_wr;
  wire logic lo_byte_wr;
  wire logic hi_byte_wr;
  wire logic lo_wen;
  wire logic hi_wen;

  // Byte writes to the control register; other accesses cancel
  assign ctrl_wr = xfer & pwrite_in & hit_ctrl;
  assign lo_byte_wr = ctrl_wr & (pstrb_in == 4'h1);
  assign hi_byte_wr = ctrl_wr & (pstrb_in == 4'h2);
  assign lo_wen = ctrl_wr & pstrb_in[0] & (lo_st_q == osc_pkg::UL_OPEN);
  assign hi_wen = ctrl_wr & pstrb_in[1] & (hi_st_q == osc_pkg::UL_OPEN);

  // Next unlock state for one byte on a completed transfer
  function automatic osc_pkg::osc_unlock_t ul_next(
    input osc_pkg::osc_unlock_t st,
    input logic bwr,
    input logic [7:0] d,
    input logic [7:0] k1,
    input logic [7:0] k2
  );
    osc_pkg::osc_unlock_t nx;
    nx = osc_pkg::UL_IDLE;
    case (st)
      osc_pkg::UL_IDLE: begin
        if (bwr && d == k1) begin
          nx = osc_pkg::UL_ARMED;
        end
      end
      osc_pkg::UL_ARMED: begin
        if (bwr && d == k2) begin
          nx = osc_pkg::UL_OPEN;
        end else if (bwr && d == k1) begin
          nx = osc_pkg::UL_ARMED;
        end
      end
      osc_pkg::UL_OPEN: nx = osc_pkg::UL_IDLE;
      default: nx = osc_pkg::UL_IDLE;
    endcase
    return nx;
  endfunction

  // Step both sequences on every completed transfer
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      lo_st_q <= osc_pkg::UL_IDLE;
      hi_st_q <= osc_pkg::UL_IDLE;
    end else if (xfer) begin
      lo_st_q <= ul_next(lo_st_q, lo_byte_wr, pwdata_in[7:0],
                         osc_pkg::LO_KEY1, osc_pkg::LO_KEY2);
      hi_st_q <= ul_next(hi_st_q, hi_byte_wr, pwdata_in[15:8],
                         osc_pkg::HI_KEY1, osc_pkg::HI_KEY2);
    end
  end

  // ==========================================================
  // Control register
  osc_pkg::osc_ctrl_t ctrl_q;
  osc_pkg::osc_ctrl_t ctrl_d;

  // Field updates, lowest priority first: software, switch done, failure
  always_comb begin
    ctrl_d = ctrl_q;
    if (!sw_en) begin
      ctrl_d.cur = cfg.fos;
      ctrl_d.swreq = 1'b0;
    end
    if (hi_wen) begin
      ctrl_d.nxt = pwdata_in[osc_pkg::NEW_LSB +: 3];
    end
    if (lo_wen) begin
      ctrl_d.post = pwdata_in[osc_pkg::POST_LSB +: 2];
      ctrl_d.sec = pwdata_in[osc_pkg::SEC_BIT];
      ctrl_d.swreq = pwdata_in[osc_pkg::SWREQ_BIT] & sw_en;
      if (!pwdata_in[osc_pkg::CF_BIT]) begin
        ctrl_d.cf = 1'b0;
      end
    end
    if (done_evt && ctrl_q.swreq && sw_en) begin
      ctrl_d.cur = ctrl_q.nxt;
      ctrl_d.swreq = 1'b0;
    end
    if (fail_evt) begin
      ctrl_d.cur = osc_pkg::GRP_FRC;
      ctrl_d.cf = 1'b1;
      ctrl_d.swreq = 1'b0;
    end
  end

  // Power-on load of both group fields from the config word
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ctrl_q <= '{cur: cfg.fos, nxt: cfg.fos, post: osc_pkg::POST_RST,
                  cf: 1'b0, sec: 1'b0, swreq: 1'b0};
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ==========================================================
  // Tuning register, unprotected
  logic [osc_pkg::TUNE_W-1:0] tune_q;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      tune_q <= osc_pkg::TUNE_RST;
    end else if (xfer && pwrite_in && hit_tune && pstrb_in[0]) begin
      tune_q <= pwdata_in[osc_pkg::TUNE_W-1:0];
    end
  end

  // ==========================================================
  // Read data assembly
  wire logic [31:0] ctrl_rd;
  wire logic [31:0] tune_rd;
  wire logic [31:0] cfgw_rd;
  wire logic [31:0] rd_mux;

  // Unimplemented positions are constant zero
  assign ctrl_rd = {16'h0000, 1'b0, ctrl_q.cur, 1'b0, ctrl_q.nxt, ctrl_q.post,
                    lock_s, 1'b0, ctrl_q.cf, 1'b0, ctrl_q.sec, ctrl_q.swreq};
  assign tune_rd = {28'h000_0000, tune_q};
  assign cfgw_rd = {16'h0000, cfg.cksm, 3'h0, cfg.fos, 3'h0, cfg.fpr};
  assign rd_mux = hit_ctrl ? ctrl_rd : hit_tune ? tune_rd : hit_cfgw ? cfgw_rd : 32'h0000_0000;

  // Answer one cycle into the access phase
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= access;
      pslverr_q <= access & ~addr_hit;
      if (access && !pwrite_in) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // ==========================================================
  // Postscaler tick divider
  logic [5:0] div_cnt_q;
  logic tick_q;
  wire logic [5:0] div_mask;

  // Mask per postscaler code
  assign div_mask = (ctrl_q.post == 2'h3) ? osc_pkg::DIV64_MASK :
                    (ctrl_q.post == 2'h2) ? osc_pkg::DIV16_MASK :
                    (ctrl_q.post == 2'h1) ? osc_pkg::DIV4_MASK : osc_pkg::DIV1_MASK;

  // Free-running count, tick when masked bits all set
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      div_cnt_q <= 6'h00;
      tick_q <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_q + 6'h01;
      tick_q <= ((div_cnt_q & div_mask) == div_mask);
    end
  end

  // ==========================================================
  // Outputs
  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign current_group_out = ctrl_q.cur;
  assign target_group_out = ctrl_q.nxt;
  assign switch_request_out = ctrl_q.swreq;
  assign primary_option_out = cfg.fpr;
  assign secondary_osc_enable_out = ctrl_q.sec;
  assign tune_field_out = tune_q;
  assign fail_safe_monitor_out = mon_en;
  assign postscaler_tick_out = tick_q;

  // ==========================================================
  // Assertions
  AST_LO_UNLOCK: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    lo_st_q == osc_pkg::UL_ARMED && lo_byte_wr && pwdata_in[7:0] == osc_pkg::LO_KEY2
    |=> lo_st_q == osc_pkg::UL_OPEN)
    else $error("low byte did not unlock after key pair");

  AST_HI_UNLOCK: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    hi_st_q == osc_pkg::UL_ARMED && hi_byte_wr && pwdata_in[15:8] == osc_pkg::HI_KEY2
    |=> hi_st_q == osc_pkg::UL_OPEN && lo_st_q != osc_pkg::UL_OPEN)
    else $error("high byte did not unlock after key pair");

  AST_RELOCK: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    lo_st_q == osc_pkg::UL_OPEN && xfer |=> lo_st_q == osc_pkg::UL_IDLE)
    else $error("low byte stayed open after one access");

  AST_LOCKED_HOLD: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    ctrl_wr && lo_st_q != osc_pkg::UL_OPEN && hi_st_q != osc_pkg::UL_OPEN
    |=> $stable(ctrl_q.post) && $stable(ctrl_q.sec) && $stable(ctrl_q.nxt))
    else $error("locked control byte changed");

  AST_FAIL_SEQ: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    fail_evt |=> ctrl_q.cur == osc_pkg::GRP_FRC && ctrl_q.cf && !ctrl_q.swreq)
    else $error("failure did not force fast RC");

  AST_SWITCH_DONE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    done_evt && ctrl_q.swreq && sw_en && !fail_evt
    |=> ctrl_q.cur == $past(ctrl_q.nxt) && !ctrl_q.swreq)
    else $error("switch completion not applied");

  AST_DISABLED_FOLLOW: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !sw_en && !fail_evt |=> ctrl_q.cur == $past(cfg.fos) && !ctrl_q.swreq)
    else $error("current group not following power-on group");

  AST_POST_DIV4: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (ctrl_q.post == 2'h1)[*6] ##0 tick_q |-> $past(tick_q, 4) && !$past(tick_q, 1))
    else $error("divide by four period wrong");

  AST_RESERVED_ZERO: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    xfer && !pwrite_in && hit_ctrl
    |-> prdata_q[31:15] == 17'h0_0000 && !prdata_q[11] && !prdata_q[4] && !prdata_q[2])
    else $error("reserved control bit read non-zero");

  AST_CF_SET_WINS: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    fail_evt && lo_wen && !pwdata_in[osc_pkg::CF_BIT] |=> ctrl_q.cf)
    else $error("fail flag lost to a clear");

  COV_LO_WRITE: cover property (@(posedge sys_clk_in) disable iff (reset_in) lo_wen);
  COV_HI_WRITE: cover property (@(posedge sys_clk_in) disable iff (reset_in) hi_wen);
  COV_SWITCH: cover property (@(posedge sys_clk_in) disable iff (reset_in)
    done_evt && ctrl_q.swreq && sw_en);
  COV_FAIL: cover property (@(posedge sys_clk_in) disable iff (reset_in) fail_evt);

endmodule // osc_select_control
`default_nettype wire

//--- verilog/osc_pkg.sv
// Shared constants and types for the oscillator select control block.
// Assumes an APB register port with 32-bit data and byte strobes.
`default_nettype none
package osc_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [11:0] CTRL_OFS = 12'h0000;
  localparam logic [11:0] TUNE_OFS = 12'h0004;
  localparam logic [11:0] CFGW_OFS = 12'h0008;

  // ==========================================================
  // Unlock keys
  localparam logic [7:0] LO_KEY1 = 8'h46;
  localparam logic [7:0] LO_KEY2 = 8'h57;
  localparam logic [7:0] HI_KEY1 = 8'h78;
  localparam logic [7:0] HI_KEY2 = 8'h9A;

  // ==========================================================
  // Oscillator group codes
  localparam logic [2:0] GRP_PLL = 3'h7;
  localparam logic [2:0] GRP_EXT = 3'h3;
  localparam logic [2:0] GRP_LOW_POWER_RC_SOURCE = 3'h2;
  localparam logic [2:0] GRP_FRC = 3'h1;
  localparam logic [2:0] GRP_LPOSC = 3'h0;

  // ==========================================================
  // Control register field positions
  localparam int CUR_LSB = 12;
  localparam int NEW_LSB = 8;
  localparam int POST_LSB = 6;
  localparam int LOCK_BIT = 5;
  localparam int CF_BIT = 3;
  localparam int SEC_BIT = 1;
  localparam int SWREQ_BIT = 0;

  // ==========================================================
  // Configuration word field positions
  localparam int CKSM_LSB = 14;
  localparam int FOS_LSB = 8;
  localparam int FPR_LSB = 0;
  localparam int TUNE_W = 4;

  // ==========================================================
  // Reset values and postscaler masks
  localparam logic [1:0] POST_RST = 2'h0;
  localparam logic [3:0] TUNE_RST = 4'h0;
  localparam logic [5:0] DIV1_MASK = 6'h00;
  localparam logic [5:0] DIV4_MASK = 6'h03;
  localparam logic [5:0] DIV16_MASK = 6'h0F;
  localparam logic [5:0] DIV64_MASK = 6'h3F;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {UL_IDLE, UL_ARMED, UL_OPEN} osc_unlock_t;

  typedef struct packed {
    logic [2:0] cur;
    logic [2:0] nxt;
    logic [1:0] post;
    logic cf;
    logic sec;
    logic swreq;
  } osc_ctrl_t;

  typedef struct packed {
    logic [1:0] cksm;
    logic [2:0] fos;
    logic [4:0] fpr;
  } osc_cfg_t;
endpackage
`default_nettype wire

//--- verif/osc_select_control_tb.sv
// Self-checking testbench for the oscillator select control block.
// Assumes the design package is compiled first; bench acts as APB master.
`timescale 1ns/10ps
`default_nettype none
module osc_select_control_tb;
  // ==========================================================
  // Signals
  logic sys_clk_in, reset_in, psel_in, penable_in, pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic [3:0] pstrb_in;
  logic pready_out, pslverr_out, er;
  logic pll_lock_in, clock_fail_in, switch_done_in;
  logic [23:0] config_word_in;
  logic [2:0] current_group_out, target_group_out;
  logic switch_request_out, secondary_osc_enable_out, fail_safe_monitor_out, postscaler_tick_out;
  logic [4:0] primary_option_out;
  logic [3:0] tune_field_out;
  int n_fail, num_checks;
  int per_tab [4] = '{1, 4, 16, 64};

  // ==========================================================
  // Device under test
  osc_select_control dut_u (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .pll_lock_in(pll_lock_in), .clock_fail_in(clock_fail_in), .switch_done_in(switch_done_in),
    .config_word_in(config_word_in), .current_group_out(current_group_out),
    .target_group_out(target_group_out), .switch_request_out(switch_request_out),
    .primary_option_out(primary_option_out), .secondary_osc_enable_out(secondary_osc_enable_out),
    .tune_field_out(tune_field_out), .fail_safe_monitor_out(fail_safe_monitor_out),
    .postscaler_tick_out(postscaler_tick_out));

  // ==========================================================
  // Clock, 4 ns period
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  // ==========================================================
  // Helpers
  task automatic finish_test();
    if (n_fail == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask

  // One APB transfer: setup, access, wait for pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int i;
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    pstrb_in <= s;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk_in);
      if (pready_out === 1'b1) break;
    end
    if (i == 20) begin
      chk("pready timeout", 32'h0000_0001, 32'h0000_0000);
      finish_test();
    end
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    chk(name, exp, rd);
  endtask

  function automatic logic [31:0] ctrl_val(input logic [2:0] cur, input logic [2:0] nxt,
    input logic [1:0] post, input logic lk, input logic cf, input logic sec, input logic req);
    return {16'h0000, 1'b0, cur, 1'b0, nxt, post, lk, 1'b0, cf, 1'b0, sec, req};
  endfunction

  function automatic logic [7:0] lo(input logic [1:0] post, input logic cf, input logic sec, input logic req);
    return {post, 2'b00, cf, 1'b0, sec, req};
  endfunction

  task automatic wr_lo(input logic [7:0] v);
    apb(1'b1, osc_pkg::CTRL_OFS, {24'h00_0000, v}, 4'h1);
  endtask

  task automatic wr_hi(input logic [7:0] v);
    apb(1'b1, osc_pkg::CTRL_OFS, {16'h0000, v, 8'h00}, 4'h2);
  endtask

  task automatic unlock_lo(input logic [7:0] v);
    wr_lo(osc_pkg::LO_KEY1);
    wr_lo(osc_pkg::LO_KEY2);
    wr_lo(v);
  endtask

  task automatic unlock_hi(input logic [7:0] v);
    wr_hi(osc_pkg::HI_KEY1);
    wr_hi(osc_pkg::HI_KEY2);
    wr_hi(v);
  endtask

  // Bounded waits on design outputs, and the switch-done pulse driver
  task automatic wait_req_low();
    int i;
    for (i = 0; i < 30 && switch_request_out !== 1'b0; i++) @(posedge sys_clk_in);
    if (i == 30) begin
      chk("request timeout", 32'h0000_0001, 32'h0000_0000);
      finish_test();
    end
    @(negedge sys_clk_in);
  endtask

  task automatic wait_tick();
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge sys_clk_in);
      if (postscaler_tick_out === 1'b1) break;
    end
    if (i == 200) begin
      chk("tick timeout", 32'h0000_0001, 32'h0000_0000);
      finish_test();
    end
  endtask

  task automatic pulse_done();
    switch_done_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    switch_done_in <= 1'b0;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    int n;
    n_fail = 0;
    num_checks = 0;
    reset_in = 1'b1;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 12'h000;
    pwdata_in = 32'h0000_0000;
    pstrb_in = 4'h0;
    pll_lock_in = 1'b0;
    clock_fail_in = 1'b0;
    switch_done_in = 1'b0;
    config_word_in = 24'h00_0305;
    repeat (6) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    // Reset values and read-only views
    rd_chk("ctrl reset", osc_pkg::CTRL_OFS, ctrl_val(3'h3, 3'h3, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
    rd_chk("tune reset", osc_pkg::TUNE_OFS, 32'h0000_0000);
    rd_chk("cfg view", osc_pkg::CFGW_OFS, 32'h0000_0305);
    chk("primary option", 32'h0000_0005, {27'h0, primary_option_out});
    chk("monitor on", 32'h0000_0001, {31'h0, fail_safe_monitor_out});
    apb(1'b1, osc_pkg::TUNE_OFS, 32'hFFFF_FFF8, 4'hF);
    rd_chk("tune rw", osc_pkg::TUNE_OFS, 32'h0000_0008);
    chk("tune out", 32'h0000_0008, {28'h0, tune_field_out});
    apb(1'b1, osc_pkg::CFGW_OFS, 32'hFFFF_FFFF, 4'hF);
    rd_chk("cfg locked", osc_pkg::CFGW_OFS, 32'h0000_0305);
    apb(1'b0, 12'h010, 32'h0000_0000, 4'h0);
    chk("unmapped err", 32'h0000_0001, {31'h0, er});
    chk("unmapped data", 32'h0000_0000, rd);
    // Locked byte ignores writes, unlocked byte takes one write
    wr_lo(lo(2'h0, 1'b0, 1'b1, 1'b0));
    rd_chk("locked low", osc_pkg::CTRL_OFS, ctrl_val(3'h3, 3'h3, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
    unlock_lo(lo(2'h0, 1'b0, 1'b1, 1'b0));
    @(negedge sys_clk_in);
    chk("secondary on", 32'h0000_0001, {31'h0, secondary_osc_enable_out});
    // Postscaler period for every code
    for (int p = 0; p < 4; p++) begin
      unlock_lo(lo(p[1:0], 1'b0, 1'b1, 1'b0));
      wait_tick();
      wait_tick();
      n = 0;
      do begin
        @(posedge sys_clk_in);
        n++;
      end while (postscaler_tick_out !== 1'b1 && n < 200);
      chk("tick period", per_tab[p], n);
    end
    wr_lo(8'h00);
    rd_chk("relocked", osc_pkg::CTRL_OFS, ctrl_val(3'h3, 3'h3, 2'h3, 1'b0, 1'b0, 1'b1, 1'b0));
    // Broken sequences: other transfer between keys, wrong key, crossed bytes
    wr_lo(osc_pkg::LO_KEY1);
    apb(1'b0, osc_pkg::TUNE_OFS, 32'h0000_0000, 4'h0);
    wr_lo(osc_pkg::LO_KEY2);
    wr_lo(8'h00);
    wr_lo(osc_pkg::LO_KEY1);
    wr_lo(8'h58);
    wr_lo(8'h00);
    wr_lo(osc_pkg::LO_KEY1);
    wr_lo(osc_pkg::LO_KEY2);
    wr_hi(8'h01);
    wr_hi(osc_pkg::HI_KEY1);
    wr_hi(osc_pkg::HI_KEY2);
    wr_lo(8'h00);
    rd_chk("cancelled", osc_pkg::CTRL_OFS, ctrl_val(3'h3, 3'h3, 2'h3, 1'b0, 1'b0, 1'b1, 1'b0));
    // High byte: new group writable, current group read-only
    unlock_hi({1'b0, osc_pkg::GRP_PLL, 1'b0, osc_pkg::GRP_FRC});
    rd_chk("high write", osc_pkg::CTRL_OFS, ctrl_val(3'h3, 3'h1, 2'h3, 1'b0, 1'b0, 1'b1, 1'b0));
    chk("target out", 32'h0000_0001, {29'h0, target_group_out});
    // Request then abort: later done is ignored
    unlock_lo(lo(2'h3, 1'b0, 1'b1, 1'b1));
    @(negedge sys_clk_in);
    chk("request out", 32'h0000_0001, {31'h0, switch_request_out});
    unlock_lo(lo(2'h3, 1'b0, 1'b1, 1'b0));
    pulse_done();
    repeat (8) @(posedge sys_clk_in);
    chk("aborted", 32'h0000_0003, {29'h0, current_group_out});
    // Completed switches to fast RC, then to PLL
    unlock_lo(lo(2'h3, 1'b0, 1'b1, 1'b1));
    pulse_done();
    wait_req_low();
    chk("switch frc", 32'h0000_0001, {29'h0, current_group_out});
    rd_chk("after switch", osc_pkg::CTRL_OFS, ctrl_val(3'h1, 3'h1, 2'h3, 1'b0, 1'b0, 1'b1, 1'b0));
    unlock_hi({5'h00, osc_pkg::GRP_PLL});
    unlock_lo(lo(2'h3, 1'b0, 1'b1, 1'b1));
    pulse_done();
    wait_req_low();
    chk("switch pll", 32'h0000_0007, {29'h0, current_group_out});
    // Clock failure during a pending request
    unlock_hi({5'h00, osc_pkg::GRP_LOW_POWER_RC_SOURCE});
    unlock_lo(lo(2'h3, 1'b0, 1'b1, 1'b1));
    clock_fail_in <= 1'b1;
    wait_req_low();
    @(posedge sys_clk_in);
    clock_fail_in <= 1'b0;
    rd_chk("failure", osc_pkg::CTRL_OFS, ctrl_val(3'h1, 3'h2, 2'h3, 1'b0, 1'b1, 1'b1, 1'b0));
    unlock_lo(lo(2'h3, 1'b0, 1'b1, 1'b0));
    rd_chk("fail clear", osc_pkg::CTRL_OFS, ctrl_val(3'h1, 3'h2, 2'h3, 1'b0, 1'b0, 1'b1, 1'b0));
    // Failure event and flag clear on the same edge: the set wins
    wr_lo(osc_pkg::LO_KEY1);
    wr_lo(osc_pkg::LO_KEY2);
    fork
      wr_lo(lo(2'h3, 1'b0, 1'b1, 1'b0));
      begin
        @(posedge sys_clk_in);
        clock_fail_in <= 1'b1;
      end
    join
    clock_fail_in <= 1'b0;
    rd_chk("set wins", osc_pkg::CTRL_OFS, ctrl_val(3'h1, 3'h2, 2'h3, 1'b0, 1'b1, 1'b1, 1'b0));
    unlock_lo(lo(2'h3, 1'b0, 1'b1, 1'b0));
    // Lock flag follows the PLL
    pll_lock_in <= 1'b1;
    repeat (6) @(posedge sys_clk_in);
    rd_chk("locked", osc_pkg::CTRL_OFS, ctrl_val(3'h1, 3'h2, 2'h3, 1'b1, 1'b0, 1'b1, 1'b0));
    pll_lock_in <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    rd_chk("unlocked", osc_pkg::CTRL_OFS, ctrl_val(3'h1, 3'h2, 2'h3, 1'b0, 1'b0, 1'b1, 1'b0));
    // Switching disabled by configuration
    config_word_in <= 24'h00_8205;
    repeat (8) @(posedge sys_clk_in);
    chk("cfg group", 32'h0000_0002, {29'h0, current_group_out});
    chk("monitor off", 32'h0000_0000, {31'h0, fail_safe_monitor_out});
    unlock_lo(lo(2'h3, 1'b0, 1'b1, 1'b1));
    @(negedge sys_clk_in);
    chk("no switching", 32'h0000_0000, {31'h0, switch_request_out});
    rd_chk("cfg view 2", osc_pkg::CFGW_OFS, 32'h0000_8205);
    finish_test();
  end
endmodule // osc_select_control_tb
`default_nettype wire
